/* File: uce_ctrl_ep.sv */
// Added by the designer: the Wishbone register port.
module uce_ctrl_ep
   import uce_pkg::*;
#(
   parameter int DEPTH = UCE_DEPTH
)
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   // Wishbone slave
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [UCE_ADDR_W-1:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   // USB engine events (same clock)
   input wire logic usb_reset_in,
   input wire logic usb_suspend_in,
   input wire logic setup_detect_in,
   input wire logic setup_acked_in,
   input wire logic out_data_ok_in,
   input wire logic in_data_acked_in,
   input wire logic read_status_done_in,
   input wire logic write_status_req_in,
   input wire logic token_in,
   input wire logic rx_byte_valid_in,
   input wire logic [7:0] rx_byte_in,
   input wire logic tx_byte_take_in,
   // USB engine answers
   output logic [7:0] tx_byte_out,
   output logic stall_hs_out,
   output logic write_status_ok_out,
   output logic irq_out
);
   // ************************************************************
   // Bus decode
   // ************************************************************
   function automatic logic hit(input logic [UCE_ADDR_W-1:0] a, input logic [11:0] idx);
      hit = (a == {idx, 2'b00});
   endfunction

   logic ack_q;
   logic req;
   logic wr;
   logic rd;
   assign req = wb_cyc_in & wb_stb_in & ~ack_q;
   assign wr = req & wb_we_in & (&wb_sel_in[1:0]);
   assign rd = req & ~wb_we_in;

   logic en_q, nstall_q, keep_q, own_q, setup_q, busy_q, mask_q;
   logic [3:0] size_q;
   logic [UCE_PTR_W-1:0] rptr_q, wptr_q;
   logic [7:0] mem_q [DEPTH];
   uce_stage_t stage_q;
   logic seen_setup_q;

   logic ctl_wr, en_rise, en_fall, sw_release, port_ok, hw_end, clr_most;
   assign ctl_wr = wr & hit(wb_adr_in, UCE_IDX_CTL);
   assign en_rise = ctl_wr & ~en_q & wb_dat_in[UCE_B_EN];
   assign en_fall = ctl_wr & en_q & ~wb_dat_in[UCE_B_EN];
   // Software hands the buffer back: next packet counts from zero
   assign sw_release = ctl_wr & en_q & own_q & ~setup_q & ~wb_dat_in[UCE_B_OWN];
   assign port_ok = en_q & ~setup_q & own_q;
   assign hw_end = read_status_done_in | (write_status_req_in & ~busy_q & stage_q == UCE_ST_STAT);
   assign clr_most = usb_reset_in | usb_suspend_in | hw_end;

   // ************************************************************
   // Control/status register
   // ************************************************************
   logic stage_stall;
   // Stall clear honoured only in data or status stage, setup clear, and only with enable written to 0
   assign stage_stall = ctl_wr & en_q & ~wb_dat_in[UCE_B_NSTALL] & ~setup_q
      & (stage_q != UCE_ST_IDLE) & ~wb_dat_in[UCE_B_EN];

   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_b_in)
      begin
         en_q <= 1'b0;
         nstall_q <= 1'b0;
         keep_q <= 1'b0;
         own_q <= 1'b0;
         setup_q <= 1'b0;
         busy_q <= 1'b0;
         seen_setup_q <= 1'b0;
      end
      else if (en_fall)
      begin
         en_q <= 1'b0;
         nstall_q <= 1'b0;
         keep_q <= 1'b0;
         own_q <= 1'b0;
         setup_q <= 1'b0;
         busy_q <= 1'b0;
         seen_setup_q <= 1'b0;
      end
      else if (en_rise)
      begin
         en_q <= 1'b1;
         keep_q <= 1'b1;
         own_q <= 1'b0;
         setup_q <= 1'b0;
         busy_q <= 1'b0;
         nstall_q <= wb_dat_in[UCE_B_NSTALL];
      end
      else if (en_q && (clr_most || stage_stall))
      begin
         nstall_q <= 1'b0;
         own_q <= 1'b0;
         setup_q <= 1'b0;
         busy_q <= 1'b0;
      end
      else if (en_q)
      begin
         // Stall-release: setup forces it set, software writes it only at enable rise
         if (setup_detect_in)
         begin
            nstall_q <= 1'b1;
            seen_setup_q <= 1'b1;
         end
         if (ctl_wr && !rx_byte_valid_in)
         begin
            keep_q <= wb_dat_in[UCE_B_KEEP] | ~(own_q & ~setup_q);
         end
         else
         begin
            keep_q <= 1'b1;
         end
         // Setup flag: hardware set wins over software clear
         if (setup_detect_in)
         begin
            setup_q <= 1'b1;
         end
         else if (ctl_wr && own_q && !wb_dat_in[UCE_B_SETUP])
         begin
            setup_q <= 1'b0;
         end
         // Ownership
         if (setup_detect_in)
         begin
            own_q <= 1'b0;
         end
         else if ((setup_acked_in && setup_q) || out_data_ok_in || in_data_acked_in)
         begin
            own_q <= 1'b1;
         end
         else if (ctl_wr && !setup_q && !wb_dat_in[UCE_B_OWN])
         begin
            own_q <= 1'b0;
         end
         // Busy
         if (setup_detect_in)
         begin
            busy_q <= 1'b0;
         end
         else if (setup_acked_in)
         begin
            busy_q <= 1'b1;
         end
         else if (ctl_wr && !setup_q && !wb_dat_in[UCE_B_BUSY])
         begin
            busy_q <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Transfer stage tracking
   // ************************************************************
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_b_in || !en_q || clr_most || stage_stall || setup_detect_in)
      begin
         stage_q <= setup_detect_in && en_q ? UCE_ST_DATA : UCE_ST_IDLE;
      end
      else if (write_status_req_in || read_status_done_in)
      begin
         stage_q <= UCE_ST_STAT;
      end
   end

   // Stall handshake for tokens while stalled, in any stage, once a setup has been seen since enable
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_b_in)
      begin
         stall_hs_out <= 1'b0;
         write_status_ok_out <= 1'b0;
      end
      else
      begin
         stall_hs_out <= token_in & en_q & ~nstall_q & seen_setup_q;
         write_status_ok_out <= write_status_req_in & en_q & ~busy_q;
      end
   end

   // ************************************************************
   // Received size
   // ************************************************************
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_b_in || en_fall || clr_most || stage_stall || setup_detect_in || sw_release)
      begin
         size_q <= UCE_SIZE_RST;
      end
      else if (rx_byte_valid_in && size_q != UCE_MAX_PKT)
      begin
         size_q <= size_q + 4'h1;
      end
   end

   // ************************************************************
   // Buffer and pointers
   // ************************************************************
   logic fifo_wr, fifo_rd, flush;
   assign fifo_wr = wr & hit(wb_adr_in, UCE_IDX_FIFO) & port_ok;
   assign fifo_rd = rd & hit(wb_adr_in, UCE_IDX_FIFO) & port_ok;
   assign flush = ctl_wr & en_q & ~wb_dat_in[UCE_B_KEEP] & own_q & ~setup_q;

   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_b_in || en_fall || en_rise || flush || setup_detect_in)
      begin
         rptr_q <= '0;
         wptr_q <= '0;
      end
      else
      begin
         if (fifo_wr || rx_byte_valid_in)
         begin
            wptr_q <= wptr_q + 1'b1;
         end
         if (fifo_rd || tx_byte_take_in)
         begin
            rptr_q <= rptr_q + 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (fifo_wr)
      begin
         mem_q[wptr_q] <= wb_dat_in[7:0];
      end
      else if (rx_byte_valid_in)
      begin
         mem_q[wptr_q] <= rx_byte_in;
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_b_in)
      begin
         tx_byte_out <= 8'h00;
      end
      else
      begin
         tx_byte_out <= mem_q[rptr_q];
      end
   end

   // ************************************************************
   // Mask and interrupt
   // ************************************************************
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_b_in)
      begin
         mask_q <= 1'b0;
         irq_out <= 1'b0;
      end
      else
      begin
         if (wr && hit(wb_adr_in, UCE_IDX_MASK))
         begin
            mask_q <= wb_dat_in[UCE_B_MASK];
         end
         irq_out <= mask_q & setup_q;
      end
   end

   // ************************************************************
   // Read mux and acknowledge
   // ************************************************************
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_b_in)
      begin
         ack_q <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
      end
      else
      begin
         ack_q <= req;
         wb_dat_out <= 32'h0000_0000;
         if (rd)
         begin
            if (hit(wb_adr_in, UCE_IDX_CTL))
            begin
               wb_dat_out[15:0] <= {en_q, nstall_q, keep_q, own_q, setup_q, busy_q, 10'h000};
            end
            else if (hit(wb_adr_in, UCE_IDX_SIZE))
            begin
               wb_dat_out[3:0] <= own_q ? size_q : UCE_SIZE_RST;
            end
            else if (hit(wb_adr_in, UCE_IDX_FIFO) && port_ok)
            begin
               wb_dat_out[7:0] <= mem_q[rptr_q];
            end
            else if (hit(wb_adr_in, UCE_IDX_PEEK) && port_ok)
            begin
               wb_dat_out[7:0] <= mem_q[rptr_q];
            end
            else if (hit(wb_adr_in, UCE_IDX_DEF))
            begin
               wb_dat_out[15:0] <= UCE_DEF_VAL;
            end
            else if (hit(wb_adr_in, UCE_IDX_MASK))
            begin
               wb_dat_out[0] <= mask_q;
            end
         end
      end
   end
   assign wb_ack_out = ack_q;

   // ************************************************************
   // Checks
   // ************************************************************
   property p_setup_set;
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (en_q && setup_detect_in && !en_fall && !clr_most && !stage_stall) |=> setup_q;
   endproperty
   a_setup_set: assert property (p_setup_set) else $error("setup flag not set");
   property p_setup_hold;
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (setup_q && !own_q && en_q && !clr_most && !stage_stall && !en_fall) |=> setup_q;
   endproperty
   a_setup_hold: assert property (p_setup_hold) else $error("setup flag cleared unowned");
   property p_irq;
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (mask_q && setup_q) |=> irq_out;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing");
   property p_busy_set;
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (en_q && setup_acked_in && !setup_detect_in && !clr_most && !stage_stall && !en_fall) |=> busy_q;
   endproperty
   a_busy_set: assert property (p_busy_set) else $error("busy not set");
   property p_busy_keep;
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (busy_q && setup_q && !setup_detect_in && !clr_most && !stage_stall && !en_fall) |=> busy_q;
   endproperty
   a_busy_keep: assert property (p_busy_keep) else $error("busy cleared with setup");
   property p_disable;
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      en_fall |=> (!nstall_q && !own_q && !setup_q && !busy_q && !keep_q && size_q == 4'h0);
   endproperty
   a_disable: assert property (p_disable) else $error("disable left bits");
   property p_enable;
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      en_rise |=> (keep_q && !own_q && !setup_q && !busy_q);
   endproperty
   a_enable: assert property (p_enable) else $error("enable forcing wrong");
   property p_size;
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      size_q <= UCE_MAX_PKT;
   endproperty
   a_size: assert property (p_size) else $error("size over eight");
   property p_peek;
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      (rd && hit(wb_adr_in, UCE_IDX_PEEK) && !tx_byte_take_in && !setup_detect_in) |=> $stable(rptr_q);
   endproperty
   a_peek: assert property (p_peek) else $error("peek moved pointer");
   c_setup: cover property (@(posedge ref_clk_in) setup_q && own_q);
   c_stall: cover property (@(posedge ref_clk_in) stall_hs_out);
   c_read: cover property (@(posedge ref_clk_in) fifo_rd);
endmodule

/* File: uce_pkg.sv */
package uce_pkg;
   // ************************************************************
   // Register word indices, byte address is index times four (printed offsets are not all word aligned)
   // ************************************************************
   localparam logic [11:0] UCE_IDX_CTL = 12'h200;
   localparam logic [11:0] UCE_IDX_SIZE = 12'h202;
   localparam logic [11:0] UCE_IDX_FIFO = 12'h206;
   localparam logic [11:0] UCE_IDX_PEEK = 12'h208;
   localparam logic [11:0] UCE_IDX_DEF = 12'h20A;
   localparam logic [11:0] UCE_IDX_MASK = 12'h20E;
   localparam int UCE_ADDR_W = 14;
   // ************************************************************
   // Control/status field positions
   // ************************************************************
   localparam int UCE_B_EN = 15;
   localparam int UCE_B_NSTALL = 14;
   localparam int UCE_B_KEEP = 13;
   localparam int UCE_B_OWN = 12;
   localparam int UCE_B_SETUP = 11;
   localparam int UCE_B_BUSY = 10;
   localparam int UCE_B_MASK = 0;
   // ************************************************************
   // Reset and fixed values
   // ************************************************************
   localparam logic [15:0] UCE_CTL_RST = 16'h0000;
   localparam logic [15:0] UCE_DEF_VAL = 16'h0000;
   localparam logic [3:0] UCE_SIZE_RST = 4'h0;
   localparam logic [3:0] UCE_MAX_PKT = 4'h8;
   localparam int UCE_DEPTH = 8;
   localparam int UCE_PTR_W = 3;
   // Stage of the current control transfer
   typedef enum logic [2:0]
   {
      UCE_ST_IDLE = 3'b001,
      UCE_ST_DATA = 3'b010,
      UCE_ST_STAT = 3'b100
   } uce_stage_t;
endpackage

/* File: uce_host_model.sv */
// ***************
// Host-side engine events
// ***************
module uce_host_model
(
   // Clock
   input wire logic clk_in,
   // Engine events and received bytes
   output logic [9:0] ev_out,
   output logic rx_valid_out,
   output logic [7:0] rx_byte_out
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      ev_out = 10'h000;
      rx_valid_out = 1'h0;
      rx_byte_out = 8'hA5;
   end

   task automatic pulse(input int k);
      @(posedge clk_in);
      ev_out[k] <= 1'h1;
      @(posedge clk_in);
      ev_out[k] <= 1'h0;
   endtask

   // Released byte lane flips so a stale value never looks valid
   task automatic send(input int n, input logic [7:0] b);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk_in);
         rx_valid_out <= 1'h1;
         rx_byte_out <= b + 8'(i);
      end
      @(posedge clk_in);
      rx_valid_out <= 1'h0;
      rx_byte_out <= ~rx_byte_out;
   endtask

   // Detection first, then bytes, then the ACK
   task automatic setup(input logic [7:0] b);
      pulse(2);
      send(8, b);
      pulse(3);
   endtask
endmodule

/* File: usb_control_endpoint_zero_test.sv */
module usb_control_endpoint_zero_test
   import uce_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ***************
   // Signals
   // ***************
   localparam logic [13:0] A_CTL = {UCE_IDX_CTL, 2'h0};
   localparam logic [13:0] A_SIZE = {UCE_IDX_SIZE, 2'h0};
   localparam logic [13:0] A_FIFO = {UCE_IDX_FIFO, 2'h0};
   localparam logic [13:0] A_PEEK = {UCE_IDX_PEEK, 2'h0};
   localparam logic [13:0] A_DEF = {UCE_IDX_DEF, 2'h0};
   localparam logic [13:0] A_MASK = {UCE_IDX_MASK, 2'h0};
   logic ref_clk_in, rst_b_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
   logic [UCE_ADDR_W-1:0] wb_adr_in;
   logic [3:0] wb_sel_in;
   logic [31:0] wb_dat_in, wb_dat_out, q;
   logic [9:0] ev;
   logic rx_valid, stall_hs_out, write_status_ok_out, irq_out;
   logic [7:0] rx_byte, tx_byte_out;
   int n_errors = 0, checked = 0, cycles = 0, n_wsok = 0, n;

   uce_ctrl_ep #(.DEPTH(UCE_DEPTH)) uce_ctrl_ep_i (.ref_clk_in, .rst_b_in, .wb_cyc_in, .wb_stb_in,
      .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .usb_reset_in(ev[0]),
      .usb_suspend_in(ev[1]), .setup_detect_in(ev[2]), .setup_acked_in(ev[3]), .out_data_ok_in(ev[4]),
      .in_data_acked_in(ev[5]), .read_status_done_in(ev[6]), .write_status_req_in(ev[7]),
      .token_in(ev[8]), .rx_byte_valid_in(rx_valid), .rx_byte_in(rx_byte), .tx_byte_take_in(ev[9]),
      .tx_byte_out, .stall_hs_out, .write_status_ok_out, .irq_out);
   uce_host_model host_i (.clk_in(ref_clk_in), .ev_out(ev), .rx_valid_out(rx_valid), .rx_byte_out(rx_byte));

   initial
   begin
      ref_clk_in = 1'h0;
      forever #12.5 ref_clk_in = ~ref_clk_in;
   end

   // Ceiling well above the few hundred cycles the run needs
   always @(posedge ref_clk_in)
   begin
      cycles++;
      if (write_status_ok_out === 1'h1)
         n_wsok++;
      if (cycles == 20000)
      begin
         $display("ERROR t=%0t exp=%h got=%h", $time, 0, cycles);
         n_errors++;
         tally_and_finish();
      end
   end
   // ***************
   // Bus and compare tasks
   // ***************
   task automatic tally_and_finish();
      $display("errors=%0d checks=%0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic bus(input logic w, input logic [13:0] a, input logic [15:0] d);
      @(posedge ref_clk_in);
      wb_cyc_in <= 1'h1;
      wb_stb_in <= 1'h1;
      wb_we_in <= w;
      wb_adr_in <= a;
      wb_dat_in <= {16'h0000, d};
      do @(posedge ref_clk_in); while (wb_ack_out !== 1'h1);
      q = wb_dat_out;
      wb_cyc_in <= 1'h0;
      wb_stb_in <= 1'h0;
   endtask

   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
         n_errors++;
      end
   endtask

   task automatic chk(input logic [13:0] a, input logic [15:0] e);
      bus(1'h0, a, 16'h0000);
      cmp(q, {16'h0000, e});
   endtask

   task automatic wr(input logic [13:0] a, input logic [15:0] d);
      bus(1'h1, a, d);
   endtask
   // ***************
   // Scenarios
   // ***************
   task automatic t_defaults();
      chk(A_CTL, UCE_CTL_RST);
      wb_sel_in <= 4'h1;
      wr(A_CTL, 16'hC000);
      wb_sel_in <= 4'hF;
      chk(A_CTL, UCE_CTL_RST);
      chk(A_SIZE, 16'h0000);
      wr(A_DEF, 16'hFFFF);
      chk(A_DEF, UCE_DEF_VAL);
      chk(A_FIFO, 16'h0000);
      chk(14'h0840, 16'h0000);
   endtask

   task automatic t_enable();
      wr(A_CTL, 16'hBC00);
      chk(A_CTL, 16'hA000);
      wr(A_MASK, 16'h0001);
   endtask

   task automatic t_setup();
      host_i.pulse(2);
      chk(A_CTL, 16'hE800);
      cmp({31'h0, irq_out}, 32'h1);
      wr(A_CTL, 16'hE000);
      chk(A_CTL, 16'hE800);
      host_i.send(8, 8'h10);
      host_i.pulse(3);
      chk(A_CTL, 16'hFC00);
      chk(A_SIZE, 16'h0008);
      chk(A_PEEK, 16'h0000);
      chk(A_FIFO, 16'h0000);
      wr(A_CTL, 16'hF800);
      chk(A_CTL, 16'hFC00);
      wr(A_CTL, 16'hF400);
      chk(A_CTL, 16'hF400);
      cmp({31'h0, irq_out}, 32'h0);
      chk(A_PEEK, 16'h0010);
      for (int i = 0; i < 8; i++)
         chk(A_FIFO, 16'h0010 + 16'(i));
   endtask

   task automatic t_write();
      wr(A_CTL, 16'hE400);
      host_i.send(4, 8'h20);
      host_i.pulse(4);
      chk(A_CTL, 16'hF400);
      chk(A_SIZE, 16'h0004);
      chk(A_PEEK, 16'h0020);
      n = n_wsok;
      host_i.pulse(7);
      repeat (4) @(posedge ref_clk_in);
      cmp(n_wsok, n);
      wr(A_CTL, 16'hF000);
      chk(A_CTL, 16'hF000);
      wr(A_CTL, 16'hB000);
      chk(A_CTL, 16'hF000);
      host_i.pulse(7);
      repeat (4) @(posedge ref_clk_in);
      cmp(n_wsok > n, 32'h1);
      chk(A_CTL, 16'hA000);
   endtask

   task automatic t_read_done();
      host_i.setup(8'h30);
      wr(A_CTL, 16'hF400);
      host_i.pulse(9);
      chk(A_PEEK, 16'h0031);
      cmp({24'h0, tx_byte_out}, 32'h31);
      host_i.pulse(5);
      host_i.pulse(6);
      chk(A_CTL, 16'hA000);
      host_i.pulse(8);
      #1;
      cmp({31'h0, stall_hs_out}, 32'h1);
   endtask

   task automatic t_abort();
      host_i.setup(8'h40);
      wr(A_CTL, 16'hF400);
      host_i.pulse(2);
      chk(A_CTL, 16'hE800);
      host_i.send(8, 8'h50);
      host_i.pulse(3);
   endtask

   task automatic t_usb_events();
      for (int k = 0; k < 2; k++)
      begin
         host_i.setup(8'h60);
         host_i.pulse(k);
         chk(A_CTL, 16'hA000);
         chk(A_SIZE, 16'h0000);
      end
   endtask

   task automatic t_disable();
      host_i.setup(8'h70);
      wr(A_CTL, 16'h0000);
      chk(A_CTL, 16'h0000);
      chk(A_SIZE, 16'h0000);
   endtask

   initial
   begin
      rst_b_in = 1'h0;
      wb_cyc_in = 1'h0;
      wb_stb_in = 1'h0;
      wb_we_in = 1'h0;
      wb_adr_in = 14'h0000;
      wb_sel_in = 4'hF;
      wb_dat_in = 32'h00000000;
      repeat (2) @(posedge ref_clk_in);
      rst_b_in <= 1'h1;
      t_defaults();
      t_enable();
      t_setup();
      t_write();
      t_read_done();
      t_abort();
      t_usb_events();
      t_disable();
      tally_and_finish();
   end
endmodule
